//--- hw/arc_top.sv
// Auto-reclose sequencer with AXI4-Lite configuration and status registers.
//
// The AXI4-Lite interface to the registers and the register addresses were left to the implementer.
`default_nettype none
`include "arc_params.svh"
// Behaviour
// - Ready when enabled, unblocked and idle.
// - In-progress state while cycle runs.
// - Manual close starts temporary block timer.
// - Breaker closing outside cycle also blocks temporarily.
// - Lockout holds until reset, clear, close, unlock.
// - Control block from port or menu.
// - Block input gives input-blocked state.
// - Disabled function reports disabled, never recloses.
// - Reclose needs status contact and unlatched trips.
// - Supply loss abandons cycle, never resumes.
// - Not-ready, two external starts, block inputs.
// - Shots per element, dead time per shot.
// - Dead time starts on contact drop or reset.
// - Dead expiry closes, supervision pulse plus 150ms.
// - Supervision expiry without close locks out, alarms.
// - Reclaim starts on close, expiry resets function.
// - Reclaim trip: next shot or lockout per inhibit.
// - Count reclosures, saturating at 16'hffff, readable total.
// - Group change waits until cycle ends.
// - Open-start option needs closed contact wired.
module arc_top
  import arc_pkg::*;
#(
  parameter int unsigned TICK_CYC = `ARC_MS_NS / `ARC_CLK_NS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        breaker_closed_contact,
  input  wire logic        breaker_open_contact,
  input  wire logic [2:0]  prot_trip,
  input  wire logic        ext_start1,
  input  wire logic        ext_start2,
  input  wire logic        ext_block,
  input  wire logic        breaker_not_ready_input,
  input  wire logic        manual_close,
  input  wire logic        reset_latched_in,
  input  wire logic        clear_key,
  input  wire logic        group_change_req,
  input  wire logic        group_sel,
  output logic             breaker_close_command,
  output logic             close_timeout_alarm,
  output arc_state_e       arc_state,
  output logic             active_group
);
  logic [5:0]        ctrl_r;
  logic [14:0]       shots_r;
  logic [4:0]        tripinh_r;
  logic [15:0]       closepw_r;
  logic [15:0]       reclaim_r;
  logic [15:0]       inhibit_r;
  logic [15:0]       dead_r [4];
  logic [15:0]       count_r;
  logic              unlock_r;
  logic              srst_r;
  logic              aw_got_r;
  logic              w_got_r;
  logic [7:0]        aw_addr_r;
  logic [31:0]       wdata_r;
  logic [3:0]        wstrb_r;
  logic [31:0]       wv;
  logic              wr_fire;
  arc_seq_e          seq_r;
  logic [2:0]        shot_r;
  logic [2:0]        src_r;
  logic              dead_run_r;
  logic              trip_any_d;
  logic              cb_closed_d;
  logic              grp_pend_r;
  logic              grp_sel_r;
  logic              tick;
  logic              seq_ld;
  logic [15:0]       seq_val;
  logic [4:0]        trips;
  logic [2:0]        nsrc;
  logic              trip_any;
  logic              cb_closed;
  logic              avail;
  logic              in_cycle;
  logic              start_ok;
  logic              dead_cond;
  logic              start_dead;
  logic              go_close;
  logic              closed_ev;
  logic              sup_to;
  logic              retrip;
  logic              lock_clear;

  arc_tmr_if seq_t ();
  arc_tmr_if inh_t ();

  function automatic logic [31:0] reg_read(input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      `ARC_OFF_CTRL:    v[5:0] = ctrl_r;
      `ARC_OFF_SHOTS:   v[14:0] = shots_r;
      `ARC_OFF_TRIPINH: v[4:0] = tripinh_r;
      `ARC_OFF_CLOSEPW: v[15:0] = closepw_r;
      `ARC_OFF_RECLAIM: v[15:0] = reclaim_r;
      `ARC_OFF_INHIBIT: v[15:0] = inhibit_r;
      `ARC_OFF_STATUS:  v[8:0] = {active_group, grp_pend_r, close_timeout_alarm, shot_r, arc_state};
      `ARC_OFF_COUNT:   v[15:0] = count_r;
      default: begin
        if (a[7:4] == `ARC_DEAD_HI && a[1:0] == 2'b00) begin
          v[15:0] = dead_r[a[3:2]];
        end
      end
    endcase
    return v;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'b00) && (a <= `ARC_OFF_LAST);
  endfunction

  function automatic logic [2:0] first_src(input logic [4:0] t);
    logic [2:0] s;
    s = 3'h0;
    for (int i = 4; i >= 0; i--) begin
      if (t[i]) begin
        s = 3'(i);
      end
    end
    return s;
  endfunction

  function automatic logic [2:0] shots_of(input logic [2:0] s);
    logic [2:0] n;
    n = shots_r[3*s +: 3];
    return (n > 3'h4) ? 3'h4 : n;
  endfunction

  // AXI4-Lite handshakes; ready is a one-cycle pulse so each accepted item is stored exactly once.
  assign wr_fire = aw_got_r && w_got_r && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready   <= 1'b0;
      wready    <= 1'b0;
      arready   <= 1'b0;
      bvalid    <= 1'b0;
      rvalid    <= 1'b0;
      bresp     <= `ARC_RESP_OKAY;
      rresp     <= `ARC_RESP_OKAY;
      rdata     <= 32'h0000_0000;
      aw_got_r  <= 1'b0;
      w_got_r   <= 1'b0;
      aw_addr_r <= 8'h00;
      wdata_r   <= 32'h0000_0000;
      wstrb_r   <= 4'h0;
    end else begin
      awready <= awvalid && !awready && !aw_got_r && !bvalid;
      wready  <= wvalid && !wready && !w_got_r && !bvalid;
      arready <= arvalid && !arready && !rvalid;
      if (awvalid && awready) begin
        aw_got_r  <= 1'b1;
        aw_addr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_fire) begin
        aw_got_r <= 1'b0;
        w_got_r  <= 1'b0;
        bvalid   <= 1'b1;
        bresp    <= addr_ok(aw_addr_r) ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= reg_read(araddr);
        rresp  <= addr_ok(araddr) ? `ARC_RESP_OKAY : `ARC_RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  always_comb begin
    wv = reg_read(aw_addr_r);
    for (int b = 0; b < 4; b++) begin
      if (wstrb_r[b]) begin
        wv[8*b +: 8] = wdata_r[8*b +: 8];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r    <= `ARC_RST_CTRL;
      shots_r   <= `ARC_RST_SHOTS;
      tripinh_r <= `ARC_RST_TRIPINH;
      closepw_r <= `ARC_RST_CLOSEPW;
      reclaim_r <= `ARC_RST_RECLAIM;
      inhibit_r <= `ARC_RST_INHIBIT;
      unlock_r  <= 1'b0;
      srst_r    <= 1'b0;
      for (int i = 0; i < 4; i++) begin
        dead_r[i] <= `ARC_RST_DEAD;
      end
    end else begin
      unlock_r <= 1'b0;
      srst_r   <= 1'b0;
      if (wr_fire && addr_ok(aw_addr_r)) begin
        case (aw_addr_r)
          `ARC_OFF_CTRL: begin
            ctrl_r   <= wv[5:0];
            unlock_r <= wv[`ARC_CTRL_UNLK];
            srst_r   <= wv[`ARC_CTRL_SRST];
          end
          `ARC_OFF_SHOTS:   shots_r <= wv[14:0];
          `ARC_OFF_TRIPINH: tripinh_r <= wv[4:0];
          `ARC_OFF_CLOSEPW: closepw_r <= wv[15:0];
          `ARC_OFF_RECLAIM: reclaim_r <= wv[15:0];
          `ARC_OFF_INHIBIT: inhibit_r <= wv[15:0];
          default: begin
            if (aw_addr_r[7:4] == `ARC_DEAD_HI) begin
              dead_r[aw_addr_r[3:2]] <= wv[15:0];
            end
          end
        endcase
      end
    end
  end

  arc_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  arc_timer u_seq_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (seq_t.tmr)
  );

  arc_timer u_inh_tmr (
    .aclk    (aclk),
    .aresetn (aresetn),
    .t       (inh_t.tmr)
  );

  assign trips      = {ext_start2, ext_start1, prot_trip};
  assign nsrc       = first_src(trips);
  assign trip_any   = |trips;
  assign cb_closed  = ctrl_r[`ARC_CTRL_WCL] ? breaker_closed_contact : !breaker_open_contact;
  // The open-start option is only usable with the closed contact wired.
  assign avail      = ctrl_r[`ARC_CTRL_EN] && ctrl_r[`ARC_CTRL_TOK]
                      && (ctrl_r[`ARC_CTRL_WCL] || ctrl_r[`ARC_CTRL_WOP])
                      && (!ctrl_r[`ARC_CTRL_DOPT] || ctrl_r[`ARC_CTRL_WCL]);
  assign in_cycle   = (seq_r == SQ_DEAD) || (seq_r == SQ_CLOSE) || (seq_r == SQ_RECLAIM);
  assign start_ok   = (seq_r == SQ_IDLE) && (arc_state == ST_READY) && trip_any && !trip_any_d
                      && (shots_of(nsrc) != 3'h0);
  assign dead_cond  = ctrl_r[`ARC_CTRL_DOPT] ? !breaker_closed_contact : !trip_any;
  assign start_dead = (seq_r == SQ_DEAD) && !dead_run_r && dead_cond;
  assign go_close   = (seq_r == SQ_DEAD) && dead_run_r && seq_t.done;
  assign closed_ev  = (seq_r == SQ_CLOSE) && cb_closed;
  assign sup_to     = (seq_r == SQ_CLOSE) && seq_t.done && !cb_closed;
  assign retrip     = (seq_r == SQ_RECLAIM) && trip_any;
  assign lock_clear = reset_latched_in || clear_key || srst_r || manual_close || unlock_r;

  always_comb begin
    seq_ld  = 1'b0;
    seq_val = 16'h0000;
    if (start_dead) begin
      seq_ld  = 1'b1;
      seq_val = dead_r[shot_r[1:0]];
    end else if (go_close) begin
      seq_ld  = 1'b1;
      seq_val = closepw_r + `ARC_SUP_EXTRA_MS;
    end else if (closed_ev) begin
      seq_ld  = 1'b1;
      seq_val = reclaim_r;
    end
  end

  assign seq_t.tick = tick;
  assign seq_t.load = seq_ld;
  assign seq_t.val  = seq_val;
  assign inh_t.tick = tick;
  assign inh_t.load = manual_close || (cb_closed && !cb_closed_d && !in_cycle);
  assign inh_t.val  = inhibit_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_any_d  <= 1'b0;
      cb_closed_d <= 1'b1;
    end else begin
      trip_any_d  <= trip_any;
      cb_closed_d <= cb_closed;
    end
  end

  // Synchronous reset is also the supply-loss path: a cycle is dropped, never resumed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      seq_r                 <= SQ_IDLE;
      shot_r                <= 3'h0;
      src_r                 <= 3'h0;
      dead_run_r            <= 1'b0;
      breaker_close_command <= 1'b0;
      close_timeout_alarm   <= 1'b0;
    end else if (!avail) begin
      seq_r                 <= SQ_IDLE;
      dead_run_r            <= 1'b0;
      breaker_close_command <= 1'b0;
    end else begin
      unique case (seq_r)
        SQ_IDLE: begin
          if (start_ok) begin
            seq_r      <= SQ_DEAD;
            shot_r     <= 3'h0;
            src_r      <= nsrc;
            dead_run_r <= 1'b0;
          end
        end
        SQ_DEAD: begin
          if (start_dead) begin
            dead_run_r <= 1'b1;
          end else if (go_close) begin
            seq_r                 <= SQ_CLOSE;
            dead_run_r            <= 1'b0;
            breaker_close_command <= !breaker_not_ready_input;
          end
        end
        SQ_CLOSE: begin
          if (closed_ev) begin
            seq_r                 <= SQ_RECLAIM;
            shot_r                <= 3'(shot_r + 3'h1);
            breaker_close_command <= 1'b0;
          end else if (sup_to) begin
            seq_r                 <= SQ_LOCK;
            close_timeout_alarm   <= 1'b1;
            breaker_close_command <= 1'b0;
          end else if (breaker_not_ready_input) begin
            breaker_close_command <= 1'b0;
          end
        end
        SQ_RECLAIM: begin
          if (retrip) begin
            src_r <= nsrc;
            if (tripinh_r[nsrc] || shot_r >= shots_of(nsrc)) begin
              seq_r <= SQ_LOCK;
            end else begin
              seq_r      <= SQ_DEAD;
              dead_run_r <= 1'b0;
            end
          end else if (seq_t.done) begin
            seq_r <= SQ_IDLE;
          end
        end
        SQ_LOCK: begin
          if (lock_clear) begin
            seq_r               <= SQ_IDLE;
            close_timeout_alarm <= 1'b0;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= 16'h0000;
    end else if (closed_ev && count_r != 16'hffff) begin
      count_r <= count_r + 16'h0001;
    end
  end

  // Disabled, lockout and blocks outrank ready, so a start is only taken from a clean ready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arc_state <= ST_DIS;
    end else if (!avail) begin
      arc_state <= ST_DIS;
    end else if (seq_r == SQ_LOCK) begin
      arc_state <= ST_LOCK;
    end else if (in_cycle) begin
      arc_state <= ST_PROG;
    end else if (ext_block) begin
      arc_state <= ST_INBLK;
    end else if (ctrl_r[`ARC_CTRL_CBLK]) begin
      arc_state <= ST_CBLK;
    end else if (inh_t.busy) begin
      arc_state <= ST_TEMP;
    end else begin
      arc_state <= ST_READY;
    end
  end

  // A request arriving together with the apply keeps the newer choice pending.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_pend_r   <= 1'b0;
      grp_sel_r    <= 1'b0;
      active_group <= 1'b0;
    end else if (group_change_req) begin
      grp_pend_r <= 1'b1;
      grp_sel_r  <= group_sel;
    end else if (grp_pend_r && !in_cycle && !seq_t.busy) begin
      grp_pend_r   <= 1'b0;
      active_group <= grp_sel_r;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_close_issued;
    (seq_r == SQ_CLOSE) ##0 seq_t.busy;
  endsequence
  sequence s_locked_alarm;
    (seq_r == SQ_LOCK) && close_timeout_alarm ##1 (arc_state == ST_LOCK);
  endsequence

  a_ready_means_idle: assert property ((arc_state == ST_READY) |-> $past(seq_r) == SQ_IDLE && $past(avail))
    else $error("ready reported outside idle");
  a_progress_shown: assert property (in_cycle && avail |=> arc_state == ST_PROG)
    else $error("cycle running without progress state");
  a_manual_temp: assert property (manual_close && avail && !in_cycle && inhibit_r != 16'h0000
                                  && !ext_block && !ctrl_r[`ARC_CTRL_CBLK] && !go_close
                                  |=> ##1 (arc_state == ST_TEMP || arc_state == ST_INBLK
                                  || arc_state == ST_CBLK || arc_state == ST_PROG))
    else $error("manual close did not block temporarily");
  a_lock_holds: assert property (seq_r == SQ_LOCK && !lock_clear && avail |=> seq_r == SQ_LOCK)
    else $error("lockout left without a clearing event");
  a_ctrl_block: assert property (ctrl_r[`ARC_CTRL_CBLK] && avail && !in_cycle && seq_r != SQ_LOCK && !ext_block
                                 |=> arc_state == ST_CBLK)
    else $error("control block not reported");
  a_input_block: assert property (ext_block && avail && !in_cycle && seq_r != SQ_LOCK |=> arc_state == ST_INBLK)
    else $error("input block not reported");
  a_disabled_idle: assert property (!avail |=> arc_state == ST_DIS && !breaker_close_command)
    else $error("disabled function still active");
  a_close_super: assert property (go_close && avail |=> s_close_issued)
    else $error("close issued without supervision timer");
  a_close_timeout: assert property (sup_to && avail |=> s_locked_alarm)
    else $error("supervision expiry did not lock out");
  a_reclaim_end: assert property (seq_r == SQ_RECLAIM && seq_t.done && !trip_any && avail |=> seq_r == SQ_IDLE)
    else $error("reclaim expiry did not reset");
  a_count_step: assert property (closed_ev && count_r != 16'hffff |=> count_r == $past(count_r) + 16'h0001)
    else $error("reclosure not counted");
  a_group_held: assert property (in_cycle |=> $stable(active_group))
    else $error("group changed during a cycle");
endmodule
`default_nettype wire

//--- hw/arc_params.svh
// Register map, field positions, reset values and timing figures of the reclose sequencer.
`ifndef ARC_PARAMS_SVH
`define ARC_PARAMS_SVH
`define ARC_CLK_NS        25
`define ARC_MS_NS         1000000
`define ARC_SUP_EXTRA_MS  16'd150
`define ARC_TW            16
`define ARC_AW            8
`define ARC_OFF_CTRL      8'h00
`define ARC_OFF_SHOTS     8'h04
`define ARC_OFF_TRIPINH   8'h08
`define ARC_OFF_CLOSEPW   8'h0c
`define ARC_OFF_RECLAIM   8'h10
`define ARC_OFF_INHIBIT   8'h14
`define ARC_OFF_STATUS    8'h18
`define ARC_OFF_COUNT     8'h1c
`define ARC_OFF_DEAD0     8'h20
`define ARC_OFF_LAST      8'h2c
`define ARC_DEAD_HI       4'h2
`define ARC_CTRL_EN       0
`define ARC_CTRL_CBLK     1
`define ARC_CTRL_DOPT     2
`define ARC_CTRL_WCL      3
`define ARC_CTRL_WOP      4
`define ARC_CTRL_TOK      5
`define ARC_CTRL_UNLK     6
`define ARC_CTRL_SRST     7
`define ARC_RST_CTRL      6'h00
`define ARC_RST_SHOTS     15'h0000
`define ARC_RST_TRIPINH   5'h00
`define ARC_RST_CLOSEPW   16'h0064
`define ARC_RST_RECLAIM   16'h2710
`define ARC_RST_INHIBIT   16'h1388
`define ARC_RST_DEAD      16'h01f4
`define ARC_RESP_OKAY     2'h0
`define ARC_RESP_SLVERR   2'h2
`endif

//--- hw/arc_pkg.sv
// Types shared by the reclose sequencer modules.
`default_nettype none
package arc_pkg;
  typedef enum logic [2:0] {ST_READY, ST_PROG, ST_TEMP, ST_LOCK, ST_CBLK, ST_INBLK, ST_DIS} arc_state_e;
  typedef enum logic [2:0] {SQ_IDLE, SQ_DEAD, SQ_CLOSE, SQ_RECLAIM, SQ_LOCK} arc_seq_e;
endpackage
`default_nettype wire

//--- hw/arc_tmr_if.sv
// Control and status link between the sequencer and one millisecond timer.
`default_nettype none
interface arc_tmr_if;
  logic             tick;
  logic             load;
  logic [15:0]      val;
  logic             busy;
  logic             done;
  modport ctl (output tick, output load, output val, input busy, input done);
  modport tmr (input tick, input load, input val, output busy, output done);
endinterface
`default_nettype wire

//--- hw/arc_tick.sv
// Millisecond time base derived from the bus clock.
`default_nettype none
module arc_tick #(
  parameter int unsigned TICK_CYC = 40000
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  output logic      tick
);
  localparam int unsigned W = $clog2(TICK_CYC);
  localparam logic [W-1:0] CMAX = W'(TICK_CYC - 1);
  logic [W-1:0] cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      tick  <= (cnt_r == CMAX);
      cnt_r <= (cnt_r == CMAX) ? '0 : W'(cnt_r + 1'b1);
    end
  end
endmodule
`default_nettype wire

//--- hw/arc_timer.sv
// Loadable down counter stepping on the millisecond tick.
`default_nettype none
module arc_timer (
  input  wire logic aclk,
  input  wire logic aresetn,
  arc_tmr_if.tmr    t
);
  logic [15:0] cnt_r;

  // A load always wins over a pending tick, so a restart never sees a stale expiry.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_r  <= 16'h0000;
      t.done <= 1'b0;
    end else if (t.load) begin
      cnt_r  <= t.val;
      t.done <= (t.val == 16'h0000);
    end else if (t.tick && cnt_r != 16'h0000) begin
      cnt_r  <= cnt_r - 16'h0001;
      t.done <= (cnt_r == 16'h0001);
    end else begin
      t.done <= 1'b0;
    end
  end

  assign t.busy = (cnt_r != 16'h0000);
endmodule
`default_nettype wire

//--- tb/arc_brk_model.sv
// Breaker model that drives the auxiliary contacts from close and open requests.
`default_nettype none
module arc_brk_model (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic close_cmd,
  input  wire logic open_req,
  input  wire logic stuck,
  input  wire logic shut,
  output var logic  closed,
  output logic      opened
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] dly_r;
  // Both contacts are wired and complementary, so reclosing stays available.
  assign opened = !closed;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      closed <= 1'h1;
      dly_r  <= 2'h0;
    end else if (open_req) begin
      closed <= 1'h0;
      dly_r  <= 2'h0;
    end else if (shut) begin
      closed <= 1'h1;
    end else if (close_cmd && !stuck) begin
      // The mechanism is slow, so the command is seen standing before the contact moves.
      dly_r <= dly_r + 2'h1;
      if (dly_r == 2'h3) closed <= 1'h1;
    end
  end
endmodule
`default_nettype wire

//--- tb/breaker_autoreclose_sequencer_test.sv
// Self-checking bench of the auto-reclose sequencer.
`default_nettype none
`include "arc_params.svh"
module breaker_autoreclose_sequencer_test;
  timeunit 1ns;
  timeprecision 1ps;
  import arc_pkg::*;
  logic        aclk = '0, aresetn = '0, awvalid = '0, wvalid = '0, bready = '0, arvalid = '0, rready = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [1:0]  bresp, rresp;
  logic [2:0]  prot_trip = '0;
  logic        ext_start1 = '0, ext_block = '0, manual_close = '0, clear_key = '0, group_change_req = '0;
  logic        group_sel = '0, open_req = '0, stuck = '0, shut = '0, reset_latched_in = '0;
  logic        awready, wready, bvalid, arready, rvalid, breaker_close_command, close_timeout_alarm;
  logic        breaker_closed_contact, breaker_open_contact, active_group;
  arc_state_e  arc_state;
  int          errors = 0, comparisons = 0;
  always #12.5 aclk = ~aclk;
  arc_top #(.TICK_CYC(4)) arc_top_inst (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .breaker_closed_contact, .breaker_open_contact, .prot_trip, .ext_start1, .ext_start2(1'h0), .ext_block,
    .breaker_not_ready_input(1'h0), .manual_close, .reset_latched_in, .clear_key, .group_change_req,
    .group_sel, .breaker_close_command, .close_timeout_alarm, .arc_state, .active_group);
  arc_brk_model arc_brk_model_inst (.aclk, .aresetn, .close_cmd(breaker_close_command), .open_req, .stuck,
    .shut, .closed(breaker_closed_contact), .opened(breaker_open_contact));
  task automatic stop_test();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic limit(input int n, input int m);
    if (n >= m) begin
      errors++;
      stop_test();
    end
  endtask
  // Waits for the state (sel 0) or the close command (sel 1); a hang ends the run.
  task automatic wait_on(input bit sel, input logic [2:0] v);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while ((sel ? {2'h0, breaker_close_command} : arc_state) !== v && n < 3000);
    limit(n, 3000);
  endtask
  task automatic span(input arc_state_e s, output int n);
    n = 0;
    while (arc_state === s && n < 3000) begin
      @(posedge aclk);
      n++;
    end
    limit(n, 3000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit aw, w;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    aw = 1;
    w = 1;
    n = 0;
    do begin
      @(posedge aclk);
      aw = aw & !awready;
      w = w & !wready;
      awvalid <= aw;
      wvalid <= w;
      n++;
    end while (!(bvalid && !aw && !w) && n < 100);
    bready <= 1'h0;
    limit(n, 100);
    check("bresp", bresp, er);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    int n;
    bit ar;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    ar = 1;
    n = 0;
    do begin
      @(posedge aclk);
      ar = ar & !arready;
      arvalid <= ar;
      n++;
    end while (!(rvalid && !ar) && n < 100);
    rready <= 1'h0;
    limit(n, 100);
    check("rdata", rdata, e);
    check("rresp", rresp, er);
  endtask
  task automatic t_regs();
    check("reset state", arc_state, ST_DIS);
    rd(`ARC_OFF_CLOSEPW, 32'h64, `ARC_RESP_OKAY);
    rd(`ARC_OFF_LAST, 32'h1f4, `ARC_RESP_OKAY);
    rd(8'h40, 32'h0, `ARC_RESP_SLVERR);
    wr(8'h40, 32'h1, `ARC_RESP_SLVERR);
    wr(`ARC_OFF_COUNT, 32'h5, `ARC_RESP_OKAY);
    rd(`ARC_OFF_COUNT, 32'h0, `ARC_RESP_OKAY);
    wr(`ARC_OFF_CLOSEPW, 32'h2, `ARC_RESP_OKAY);
    wr(`ARC_OFF_RECLAIM, 32'ha, `ARC_RESP_OKAY);
    wr(`ARC_OFF_INHIBIT, 32'h5, `ARC_RESP_OKAY);
    wr(`ARC_OFF_DEAD0, 32'h3, `ARC_RESP_OKAY);
    wr(`ARC_OFF_SHOTS, 32'h201, `ARC_RESP_OKAY);
    rd(`ARC_OFF_SHOTS, 32'h201, `ARC_RESP_OKAY);
    wr(`ARC_OFF_CTRL, 32'h29, `ARC_RESP_OKAY);
    wait_on(0, ST_READY);
  endtask
  task automatic t_cycle();
    prot_trip <= 3'h1;
    open_req <= 1'h1;
    wait_on(0, ST_PROG);
    group_sel <= 1'h1;
    group_change_req <= 1'h1;
    @(posedge aclk);
    group_change_req <= 1'h0;
    prot_trip <= 3'h0;
    open_req <= 1'h0;
    wait_on(1, 3'h1);
    check("group held", active_group, 1'h0);
    wait_on(1, 3'h0);
    check("close in cycle", arc_state, ST_PROG);
    wait_on(0, ST_READY);
    check("group applied", active_group, 1'h1);
    rd(`ARC_OFF_COUNT, 32'h1, `ARC_RESP_OKAY);
  endtask
  task automatic t_timeout();
    int n;
    stuck <= 1'h1;
    ext_start1 <= 1'h1;
    open_req <= 1'h1;
    wait_on(0, ST_PROG);
    ext_start1 <= 1'h0;
    open_req <= 1'h0;
    wait_on(1, 3'h1);
    span(ST_PROG, n);
    check("supervision", n >= (`ARC_SUP_EXTRA_MS + 1) * 4 && n <= (`ARC_SUP_EXTRA_MS + 4) * 4, 1'h1);
    check("lockout", arc_state, ST_LOCK);
    check("alarm", close_timeout_alarm, 1'h1);
    check("cmd", breaker_close_command, 1'h0);
    repeat (20) @(posedge aclk);
    check("lock held", arc_state, ST_LOCK);
    clear_key <= 1'h1;
    @(posedge aclk);
    clear_key <= 1'h0;
    stuck <= 1'h0;
    wait_on(0, ST_READY);
    check("alarm clear", close_timeout_alarm, 1'h0);
  endtask
  task automatic t_temp();
    int n;
    shut <= 1'h1;
    @(posedge aclk);
    shut <= 1'h0;
    wait_on(0, ST_TEMP);
    wait_on(0, ST_READY);
    manual_close <= 1'h1;
    @(posedge aclk);
    manual_close <= 1'h0;
    wait_on(0, ST_TEMP);
    span(ST_TEMP, n);
    check("inhibit time", n >= 16 && n <= 24, 1'h1);
    check("after temp", arc_state, ST_READY);
  endtask
  task automatic t_block();
    wr(`ARC_OFF_CTRL, 32'h2b, `ARC_RESP_OKAY);
    wait_on(0, ST_CBLK);
    ext_block <= 1'h1;
    wait_on(0, ST_INBLK);
    prot_trip <= 3'h1;
    repeat (8) @(posedge aclk);
    check("blocked start", arc_state, ST_INBLK);
    wr(`ARC_OFF_CTRL, 32'h28, `ARC_RESP_OKAY);
    wait_on(0, ST_DIS);
    check("no close", breaker_close_command, 1'h0);
    prot_trip <= 3'h0;
    ext_block <= 1'h0;
  endtask
  task automatic t_retrip();
    wr(`ARC_OFF_CTRL, 32'h2d, `ARC_RESP_OKAY);
    wait_on(0, ST_READY);
    prot_trip <= 3'h1;
    open_req <= 1'h1;
    wait_on(0, ST_PROG);
    open_req <= 1'h0;
    wait_on(1, 3'h1);
    prot_trip <= 3'h0;
    wait_on(1, 3'h0);
    prot_trip <= 3'h1;
    wait_on(0, ST_LOCK);
    check("no alarm", close_timeout_alarm, 1'h0);
    reset_latched_in <= 1'h1;
    prot_trip <= 3'h0;
    @(posedge aclk);
    reset_latched_in <= 1'h0;
    wait_on(0, ST_READY);
  endtask
  task automatic t_supply();
    wr(`ARC_OFF_CTRL, 32'h29, `ARC_RESP_OKAY);
    wait_on(0, ST_READY);
    prot_trip <= 3'h1;
    wait_on(0, ST_PROG);
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    prot_trip <= 3'h0;
    check("abandoned", arc_state, ST_DIS);
    wr(`ARC_OFF_CTRL, 32'h29, `ARC_RESP_OKAY);
    wait_on(0, ST_READY);
    repeat (40) @(posedge aclk);
    check("no resume", breaker_close_command, 1'h0);
  endtask
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
    t_regs();
    t_cycle();
    t_timeout();
    t_temp();
    t_block();
    t_retrip();
    t_supply();
    stop_test();
  end
endmodule
`default_nettype wire
